// *** ipc_asserts.sv ***
`timescale 1ns/10ps
`include "ipc_defines.vh"
module ipc_asserts
(
  input wire        clk_sys,
  input wire        sys_rst,
  input wire [11:0] reg_addr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire        irq_req,
  input wire        irq_ack,
  input wire [20:0] irq_vector,
  input wire        stack_push,
  input wire [20:0] stack_push_data,
  input wire [20:0] cpu_pc,
  input wire [7:0]  working_accumulator,
  input wire [7:0]  shadow_working_accumulator,
  input wire [7:0]  cpu_status,
  input wire [7:0]  shadow_status,
  input wire [7:0]  bank_select,
  input wire [7:0]  shadow_bsr,
  input wire        cpu_sleeping,
  input wire        wake_req
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ==========
  // Accept steps
  sequence s_take;
    irq_req && irq_ack;
  endsequence
  sequence s_take_high;
    s_take ##0 irq_vector == `IPC_VEC_HIGH;
  endsequence
  a_ack_push: assert property (s_take |=> stack_push && stack_push_data == $past(cpu_pc))
    else $error("push missing after accept");
  a_shadow_copy: assert property (s_take |=> shadow_working_accumulator == $past(working_accumulator)
    && shadow_status == $past(cpu_status) && shadow_bsr == $past(bank_select))
    else $error("shadow not loaded");
  a_push_once: assert property (stack_push |=> !stack_push)
    else $error("push longer than one cycle");
  a_high_final: assert property (s_take_high |-> ##2 !irq_req)
    else $error("request during high service");
  a_vec_legal: assert property (irq_req |-> irq_vector inside {`IPC_VEC_HIGH, `IPC_VEC_LOW})
    else $error("bad vector");
  a_wake_sleep: assert property (wake_req |-> $past(cpu_sleeping))
    else $error("wake while awake");
  a_ctl_gap: assert property (reg_rd && reg_addr == `IPC_ADDR_RCTL |=> reg_rdata[6:5] == 2'b00)
    else $error("control gap bits set");
  a_flag_resv: assert property (reg_rd && reg_addr == `IPC_ADDR_PIR |=> (reg_rdata & 8'hEB) == 8'h00)
    else $error("flag reserved bits set");
endmodule

// *** ipc_core_model.sv ***
`timescale 1ns/10ps
module ipc_core_model
(
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        irq_req,
  input  wire [20:0] irq_vector,
  input  wire        ack_on,
  input  wire        ret_cmd,
  output reg         irq_ack,
  output reg         irq_return,
  output reg  [20:0] cpu_pc,
  output reg  [20:0] taken_vec
);
  // ==========
  // Core sequencer stand-in
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      irq_ack    <= 1'b0;
      irq_return <= 1'b0;
      cpu_pc     <= 21'h000100;
      taken_vec  <= 21'h000000;
    end
    else
    begin
      // Moving PC so every push carries a fresh value
      cpu_pc     <= cpu_pc + 21'h000001;
      // one-cycle accept of a pending request
      irq_ack    <= irq_req && ack_on && !irq_ack;
      irq_return <= ret_cmd;
      // Remember where the core would branch
      if (irq_req && irq_ack)
        taken_vec <= irq_vector;
    end
  end
endmodule

// *** ipc_defines.vh ***
`ifndef IPC_DEFINES_VH
`define IPC_DEFINES_VH
// ==========================================
// Register word addresses (12-bit space)
`define IPC_ADDR_PIE       12'hFA0
`define IPC_ADDR_PIR       12'hFA1
`define IPC_ADDR_IPR       12'hFA2
`define IPC_ADDR_RCTL      12'hFD0
`define IPC_ADDR_MAIN      12'hFF2
`define IPC_ADDR_SEC       12'hFF1
`define IPC_ADDR_PCDE      12'hF78
`define IPC_ADDR_VEC       12'hF70
// ==========================================
// Bit positions
`define IPC_B_PRIO_ON      7
`define IPC_B_NV           4
`define IPC_B_LV           2
`define IPC_B_HIGH_LEVEL_GLOBAL_ENABLE         7
`define IPC_B_LOW_LEVEL_GLOBAL_ENABLE         6
`define IPC_B_TMR_EN       5
`define IPC_B_EXT_EN       4
`define IPC_B_PC_EN        3
`define IPC_B_TMR_FL       2
`define IPC_B_EXT_FL       1
`define IPC_B_PC_FL        0
`define IPC_B_EDGE         6
`define IPC_B_TMR_PRI      2
`define IPC_B_PC_PRI       0
// ==========================================
// Reset values, masks and pin count
`define IPC_RST_ZERO       8'h00
`define IPC_RST_IPR        8'h14
`define IPC_RST_SEC        8'hC5
`define IPC_RST_PCDE       6'h00
`define IPC_RST_PC         21'h000000
`define IPC_MASK_ALL       8'hFF
`define IPC_MASK_PERI      8'h14
`define IPC_MASK_SEC       8'hC5
`define IPC_MASK_PCDE      8'h3F
`define IPC_PINS           6
// ==========================================
// Vector addresses and timer maxima
`define IPC_VEC_HIGH       21'h000008
`define IPC_VEC_LOW        21'h000018
`define IPC_T8_MAX         8'hFF
`define IPC_T16_MAX        16'hFFFF
`endif

// *** ipc_top.v ***
`timescale 1ns/10ps
`include "ipc_defines.vh"
module ipc_top
(
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire [11:0] reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire        nv_write_done,
  input  wire        low_supply_det,
  input  wire        ext_irq_pin,
  input  wire [5:0]  io_port_pins,
  input  wire        port_read,
  input  wire        timer_tick,
  input  wire        timer_16bit,
  input  wire [15:0] basic_timer,
  input  wire [4:0]  reset_status,
  input  wire        cpu_sleeping,
  input  wire        irq_ack,
  input  wire        irq_return,
  input  wire [20:0] cpu_pc,
  input  wire [7:0]  working_accumulator,
  input  wire [7:0]  cpu_status,
  input  wire [7:0]  bank_select,
  output reg         irq_req,
  output reg  [20:0] irq_vector,
  output reg         wake_req,
  output reg         stack_push,
  output reg  [20:0] stack_push_data,
  output reg  [7:0]  shadow_working_accumulator,
  output reg  [7:0]  shadow_status,
  output reg  [7:0]  shadow_bsr
);

  // ==========================================
  // Behaviour notes for the next engineer
  // Register bus
  // - One write strobe cycle, effect on the next edge
  // - One read strobe cycle, data in the next cycle only
  // - Read data returns to zero when no read is taken
  // - Unmapped writes ignored, unmapped reads give zero
  // - Reserved bits are masked on write, so they read zero
  // Flags
  // - Every flag is sticky until software writes it low
  // - Hardware set beats a same-cycle software clear
  // - Reason: a clear must never swallow a fresh event
  // - Flags set even with enables off, for polling
  // External pin
  // - Sampled once per clock, edge against last sample
  // - Reset sample is low, so a high pin after reset
  //   looks like a rising edge; software clears first
  // - No filtering: glitches of one clock count as edges
  // Timer overflow
  // - Tick while the count sits at its maximum
  // - Mode input picks 8-bit or 16-bit comparison
  // Port change
  // - Snapshot taken on each port read
  // - Flag set every cycle an enabled pin mismatches
  // - Limitation: clearing the flag alone does not stick
  //   while the mismatch stays; read the port first
  // Request path
  // - Requests are registered, so two edges after the event
  // - Trade-off: one extra cycle of latency for clean timing
  // - Accept only counts while a take condition still holds
  // - Accept clears the global enable of the level taken
  // - Software sets it again on return
  // Levels
  // - Priority mode: high and low gates apart
  // - A low request waits behind an enabled high one
  // - A high request with its gate off does not block low
  // - Compatibility mode: everything uses the high vector
  // Service tracking
  // - One flag per level; return pops high before low
  // - Context store is one level deep only
  // - Hazard: a nested high entry overwrites the low
  //   context; the core must handle that case itself
  // Wake-up
  // - Any enabled pending source wakes a sleeping core
  // - Global enables play no part in wake-up

  // ==========================================
  // Storage
  reg        prio_on_reg;          // Priority mode
  reg  [7:0] pie_reg;              // Peripheral enables
  reg  [7:0] pir_reg;              // Peripheral flags
  reg  [7:0] ipr_reg;              // Peripheral priorities
  reg  [7:0] main_reg;             // Main control
  reg  [7:0] sec_reg;              // Secondary control
  reg  [5:0] pcde_reg;             // Per-pin change enables
  reg        ext_pin_reg;          // Previous ext pin level
  reg  [5:0] port_snap_reg;        // Port value at last read
  reg        in_high_reg;          // Servicing high level
  reg        in_low_reg;           // Servicing low level
  reg  [7:0] rdata_next;           // Read mux
  // Write decode pulses
  wire wr_pie  = reg_wr && reg_addr == `IPC_ADDR_PIE;
  wire wr_pir  = reg_wr && reg_addr == `IPC_ADDR_PIR;
  wire wr_ipr  = reg_wr && reg_addr == `IPC_ADDR_IPR;
  wire wr_rctl = reg_wr && reg_addr == `IPC_ADDR_RCTL;
  wire wr_main = reg_wr && reg_addr == `IPC_ADDR_MAIN;
  wire wr_sec  = reg_wr && reg_addr == `IPC_ADDR_SEC;
  wire wr_pcde = reg_wr && reg_addr == `IPC_ADDR_PCDE;

  // ==========================================
  // Event detection
  // edge polarity select
  wire ext_edge = sec_reg[`IPC_B_EDGE] ? (ext_irq_pin && !ext_pin_reg)
                                       : (!ext_irq_pin && ext_pin_reg);
  wire tmr_ovf = timer_tick && (timer_16bit ? (basic_timer == `IPC_T16_MAX)
                                            : (basic_timer[7:0] == `IPC_T8_MAX));
  wire pc_event = |((io_port_pins ^ port_snap_reg) & pcde_reg);

  // Flag merge: hardware set beats software clear
  function [7:0] ipc_merge;
    input [7:0] cur;
    input       wr;
    input [7:0] wd;
    input [7:0] set;
    input [7:0] mask;
    begin
      ipc_merge = (((wr ? wd : cur) | set) & mask);
    end
  endfunction

  // ==========================================
  // Request resolution
  wire nv_pend  = pir_reg[`IPC_B_NV] && pie_reg[`IPC_B_NV];
  wire lv_pend  = pir_reg[`IPC_B_LV] && pie_reg[`IPC_B_LV];
  wire ext_pend = main_reg[`IPC_B_EXT_FL] && main_reg[`IPC_B_EXT_EN];
  // timer gated by main bit 5
  wire tmr_pend = main_reg[`IPC_B_TMR_FL] && main_reg[`IPC_B_TMR_EN];
  wire pc_pend  = main_reg[`IPC_B_PC_FL] && main_reg[`IPC_B_PC_EN];
  wire hi_any = ext_pend
             || (tmr_pend && sec_reg[`IPC_B_TMR_PRI])
             || (pc_pend && sec_reg[`IPC_B_PC_PRI])
             || (nv_pend && ipr_reg[`IPC_B_NV])
             || (lv_pend && ipr_reg[`IPC_B_LV]);
  wire lo_any = (tmr_pend && !sec_reg[`IPC_B_TMR_PRI])
             || (pc_pend && !sec_reg[`IPC_B_PC_PRI])
             || (nv_pend && !ipr_reg[`IPC_B_NV])
             || (lv_pend && !ipr_reg[`IPC_B_LV]);
  wire peri_any = nv_pend || lv_pend;
  wire core_any = ext_pend || tmr_pend || pc_pend;
  wire high_level_global_enable = main_reg[`IPC_B_HIGH_LEVEL_GLOBAL_ENABLE];
  wire low_level_global_enable = main_reg[`IPC_B_LOW_LEVEL_GLOBAL_ENABLE];
  wire take_hi = prio_on_reg && high_level_global_enable && hi_any && !in_high_reg;
  // low waits while any service runs
  // Of the requests, only an enabled high one holds the low level back
  wire take_lo = prio_on_reg && low_level_global_enable && lo_any && !(high_level_global_enable && hi_any) && !in_high_reg && !in_low_reg;
  wire take_cm = !prio_on_reg && high_level_global_enable && (core_any || (low_level_global_enable && peri_any)) && !in_high_reg;
  wire wake_any = core_any || peri_any;

  // ==========================================
  // Register writes and flags
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      prio_on_reg   <= 1'b0;
      pie_reg       <= `IPC_RST_ZERO;
      pir_reg       <= `IPC_RST_ZERO;
      ipr_reg       <= `IPC_RST_IPR;
      main_reg      <= `IPC_RST_ZERO;
      sec_reg       <= `IPC_RST_SEC;
      pcde_reg      <= `IPC_RST_PCDE;
      ext_pin_reg   <= 1'b0;
      port_snap_reg <= `IPC_RST_PCDE;
    end
    else
    begin
      ext_pin_reg <= ext_irq_pin;
      // Port read ends the mismatch condition
      if (port_read)
      begin
        port_snap_reg <= io_port_pins;
      end
      if (wr_rctl)
      begin
        prio_on_reg <= reg_wdata[`IPC_B_PRIO_ON];
      end
      if (wr_pie)
      begin
        pie_reg <= reg_wdata & `IPC_MASK_PERI;
      end
      if (wr_ipr)
      begin
        ipr_reg <= reg_wdata & `IPC_MASK_PERI;
      end
      if (wr_sec)
      begin
        sec_reg <= reg_wdata & `IPC_MASK_SEC;
      end
      if (wr_pcde)
      begin
        pcde_reg <= reg_wdata[5:0];
      end
      pir_reg <= ipc_merge(pir_reg, wr_pir, reg_wdata,
                           {3'h0, nv_write_done, 1'b0, low_supply_det, 2'h0}, `IPC_MASK_PERI);
      // main flags, set wins over clear
      main_reg <= ipc_merge(main_reg, wr_main, reg_wdata,
                            {5'h00, tmr_ovf, ext_edge, pc_event}, `IPC_MASK_ALL);
      // Entry clears the global enable of the level taken
      if (irq_ack && take_lo)
      begin
        main_reg[`IPC_B_LOW_LEVEL_GLOBAL_ENABLE] <= 1'b0;
      end
      else if (irq_ack && (take_hi || take_cm))
      begin
        main_reg[`IPC_B_HIGH_LEVEL_GLOBAL_ENABLE] <= 1'b0;
      end
    end
  end

  // ==========================================
  // Service tracking and core outputs
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      in_high_reg     <= 1'b0;
      in_low_reg      <= 1'b0;
      irq_req         <= 1'b0;
      irq_vector      <= `IPC_VEC_HIGH;
      wake_req        <= 1'b0;
      stack_push      <= 1'b0;
      stack_push_data <= `IPC_RST_PC;
      shadow_working_accumulator     <= `IPC_RST_ZERO;
      shadow_status   <= `IPC_RST_ZERO;
      shadow_bsr      <= `IPC_RST_ZERO;
    end
    else
    begin
      irq_req    <= take_hi || take_lo || take_cm;
      irq_vector <= take_lo ? `IPC_VEC_LOW : `IPC_VEC_HIGH;
      wake_req   <= cpu_sleeping && wake_any;
      stack_push <= 1'b0;
      if (irq_ack && (take_hi || take_lo || take_cm))
      begin
        // push return PC and shadow context
        stack_push      <= 1'b1;
        stack_push_data <= cpu_pc;
        shadow_working_accumulator     <= working_accumulator;
        shadow_status   <= cpu_status;
        shadow_bsr      <= bank_select;
        if (take_lo)
        begin
          in_low_reg <= 1'b1;
        end
        else
        begin
          in_high_reg <= 1'b1;
        end
      end
      else if (irq_return)
      begin
        // Innermost level returns first
        if (in_high_reg)
        begin
          in_high_reg <= 1'b0;
        end
        else
        begin
          in_low_reg <= 1'b0;
        end
      end
    end
  end

  // ==========================================
  // Read mux
  always @*
  begin
    rdata_next = `IPC_RST_ZERO;
    case (reg_addr)
      `IPC_ADDR_RCTL: rdata_next = {prio_on_reg, 2'b00, reset_status};
      `IPC_ADDR_PIE:  rdata_next = pie_reg;
      `IPC_ADDR_PIR:  rdata_next = pir_reg;
      `IPC_ADDR_IPR:  rdata_next = ipr_reg;
      `IPC_ADDR_MAIN: rdata_next = main_reg;
      `IPC_ADDR_SEC:  rdata_next = sec_reg;
      `IPC_ADDR_PCDE: rdata_next = {2'b00, pcde_reg};
      default:        rdata_next = `IPC_RST_ZERO;
    endcase
  end

  // Read data valid one cycle after strobe
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      reg_rdata <= `IPC_RST_ZERO;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rdata_next;
    end
    else
    begin
      reg_rdata <= `IPC_RST_ZERO;
    end
  end

endmodule

// *** tb.sv ***
`timescale 1ns/10ps
`include "ipc_defines.vh"
module tb;
  // ==========
  // Drives and observed outputs
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        nv_write_done = 1'b0;
  logic        low_supply_det = 1'b0;
  logic        ext_irq_pin = 1'b0;
  logic [5:0]  io_port_pins = 6'h00;
  logic        port_read = 1'b0;
  logic        timer_tick = 1'b0;
  logic        timer_16bit = 1'b0;
  logic [15:0] basic_timer = 16'h0000;
  logic        cpu_sleeping = 1'b0;
  logic        ack_on = 1'b1;
  logic        ret_cmd = 1'b0;
  wire  [7:0]  reg_rdata;
  wire  [20:0] irq_vector, cpu_pc, taken_vec;
  wire         irq_req, irq_ack, irq_return, wake_req, stack_push;
  integer      fails = 0;
  integer      num_checks = 0;
  integer      cyc = 0;
  always #5 clk_sys = ~clk_sys;
  ipc_top u_dut (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .nv_write_done, .low_supply_det, .ext_irq_pin, .io_port_pins, .port_read, .timer_tick,
    .timer_16bit, .basic_timer, .reset_status(5'h15), .cpu_sleeping, .irq_ack, .irq_return,
    .cpu_pc, .working_accumulator(cpu_pc[7:0]), .cpu_status(cpu_pc[15:8]), .bank_select(~cpu_pc[7:0]),
    .irq_req, .irq_vector, .wake_req, .stack_push, .stack_push_data(), .shadow_working_accumulator(),
    .shadow_status(), .shadow_bsr());
  ipc_core_model u_core (.clk_sys, .sys_rst, .irq_req, .irq_vector, .ack_on, .ret_cmd,
    .irq_ack, .irq_return, .cpu_pc, .taken_vec);
  // ==========
  // Hang guard
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (cyc == 4000)
    begin
      fails = fails + 1;
      give_verdict;
    end
  end
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input string n, input logic [20:0] s, input logic [20:0] e);
    begin
      num_checks = num_checks + 1;
      if (s !== e)
      begin
        fails = fails + 1;
        $display("BAD %s exp %h seen %h", n, e, s);
      end
    end
  endtask
  // ==========
  // Register bus cycles
  task wr(input logic [11:0] a, input logic [7:0] d);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk("rdata", {13'h0, reg_rdata}, {13'h0, e});
    end
  endtask
  // Wait for the core to take a request, then judge the vector
  task take(input logic [20:0] v);
    integer i;
    begin
      for (i = 0; i < 20 && stack_push !== 1'b1; i = i + 1)
        @(posedge clk_sys) #1;
      chk("vector", taken_vec, v);
    end
  endtask
  // Handler epilogue: clear flags, then return
  task done;
    begin
      wr(`IPC_ADDR_MAIN, 8'h00);
      wr(`IPC_ADDR_PIR, 8'h00);
      @(posedge clk_sys);
      ret_cmd <= 1'b1;
      @(posedge clk_sys);
      ret_cmd <= 1'b0;
    end
  endtask
  task tk(input logic [15:0] c);
    begin
      @(posedge clk_sys);
      basic_timer <= c;
      timer_tick <= 1'b1;
      @(posedge clk_sys);
      timer_tick <= 1'b0;
    end
  endtask
  // ==========
  // Scenarios
  task t_regs;
    begin
      rd(`IPC_ADDR_PIE, 8'h00);
      rd(`IPC_ADDR_IPR, 8'h14);
      rd(`IPC_ADDR_RCTL, 8'h15);
      rd(`IPC_ADDR_PCDE, 8'h00);
      wr(`IPC_ADDR_RCTL, 8'hFF);
      rd(`IPC_ADDR_RCTL, 8'h95);
      wr(`IPC_ADDR_IPR, 8'hEB);
      rd(`IPC_ADDR_IPR, 8'h00);
      rd(12'hF00, 8'h00);
      $display("registers done");
    end
  endtask
  task t_ext;
    integer k;
    begin
      for (k = 0; k < 2; k = k + 1)
      begin
        wr(`IPC_ADDR_SEC, {2'b11 ^ k[1:0], 6'h05});
        wr(`IPC_ADDR_MAIN, 8'h90);
        @(posedge clk_sys);
        ext_irq_pin <= ~k[0];
        take(`IPC_VEC_HIGH);
        done;
      end
      wr(`IPC_ADDR_MAIN, 8'h80);
      @(posedge clk_sys);
      ext_irq_pin <= 1'b1;
      rd(`IPC_ADDR_MAIN, 8'h80);
      ext_irq_pin <= 1'b0;
      rd(`IPC_ADDR_MAIN, 8'h82);
      chk("req", {20'h0, irq_req}, 21'h0);
      cpu_sleeping <= 1'b1;
      wr(`IPC_ADDR_MAIN, 8'h12);
      repeat (2) @(posedge clk_sys);
      #1 chk("wake", {20'h0, wake_req}, 21'h1);
      chk("req", {20'h0, irq_req}, 21'h0);
      cpu_sleeping <= 1'b0;
      done;
      $display("external done");
    end
  endtask
  task t_prio;
    begin
      wr(`IPC_ADDR_IPR, 8'h04);
      wr(`IPC_ADDR_PIE, 8'h14);
      wr(`IPC_ADDR_MAIN, 8'hC0);
      nv_write_done <= 1'b1;
      @(posedge clk_sys);
      nv_write_done <= 1'b0;
      take(`IPC_VEC_LOW);
      wr(`IPC_ADDR_SEC, 8'hC5);
      wr(`IPC_ADDR_MAIN, 8'h90);
      ext_irq_pin <= 1'b1;
      take(`IPC_VEC_HIGH);
      done;
      done;
      wr(`IPC_ADDR_MAIN, 8'h80);
      low_supply_det <= 1'b1;
      take(`IPC_VEC_HIGH);
      low_supply_det <= 1'b0;
      rd(`IPC_ADDR_PIR, 8'h04);
      done;
      wr(`IPC_ADDR_RCTL, 8'h00);
      wr(`IPC_ADDR_IPR, 8'h00);
      wr(`IPC_ADDR_PIE, 8'h10);
      ack_on <= 1'b0;
      wr(`IPC_ADDR_MAIN, 8'hC0);
      nv_write_done <= 1'b1;
      @(posedge clk_sys);
      nv_write_done <= 1'b0;
      repeat (5) @(posedge clk_sys);
      #1 chk("req", {20'h0, irq_req}, 21'h1);
      ack_on <= 1'b1;
      take(`IPC_VEC_HIGH);
      done;
      $display("priority done");
    end
  endtask
  task t_timer;
    begin
      tk(16'h00FF);
      rd(`IPC_ADDR_MAIN, 8'h04);
      wr(`IPC_ADDR_MAIN, 8'h00);
      timer_16bit <= 1'b1;
      tk(16'h00FF);
      rd(`IPC_ADDR_MAIN, 8'h00);
      wr(`IPC_ADDR_SEC, 8'h40);
      wr(`IPC_ADDR_RCTL, 8'h80);
      wr(`IPC_ADDR_MAIN, 8'h60);
      tk(16'hFFFF);
      take(`IPC_VEC_LOW);
      done;
      $display("timer done");
    end
  endtask
  task t_port;
    begin
      wr(`IPC_ADDR_PCDE, 8'h01);
      io_port_pins <= 6'h02;
      rd(`IPC_ADDR_MAIN, 8'h00);
      io_port_pins <= 6'h03;
      rd(`IPC_ADDR_MAIN, 8'h01);
      wr(`IPC_ADDR_SEC, 8'h41);
      wr(`IPC_ADDR_MAIN, 8'h88);
      take(`IPC_VEC_HIGH);
      port_read <= 1'b1;
      @(posedge clk_sys);
      port_read <= 1'b0;
      done;
      $display("port done");
    end
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs;
    t_ext;
    t_prio;
    t_timer;
    t_port;
    give_verdict;
  end
endmodule
bind ipc_top ipc_asserts u_chk (.clk_sys, .sys_rst, .reg_addr, .reg_rd, .reg_rdata, .irq_req, .irq_ack,
  .irq_vector, .stack_push, .stack_push_data, .cpu_pc, .working_accumulator, .shadow_working_accumulator,
  .cpu_status, .shadow_status, .bank_select, .shadow_bsr, .cpu_sleeping, .wake_req);
